// ---- shared/dcost_defs.svh ----
`ifndef DCOST_DEFS_SVH
`define DCOST_DEFS_SVH

// Word widths.
`define DCOST_FREQ_W        42
`define DCOST_FREQ_REG_W    48
`define DCOST_PHASE_W       32
`define DCOST_TIMER_W       16
`define DCOST_ERR_W         32

// Offset range limits in frequency control word units, +244.20ppm and -244.08ppm.
`define DCOST_FREQ_MAX      42'sh1FF_FFFF_FFFF
`define DCOST_FREQ_MIN      -42'sh200_0000_0000

// Timing: one millisecond tick at 100 MHz.
`define DCOST_CLK_MHZ       100
`define DCOST_TICK_US       1000
`define DCOST_TICK_CYCLES   (`DCOST_TICK_US * `DCOST_CLK_MHZ)

// Reset values.
`define DCOST_FREQ_RST      48'h0000_0000_0000
`define DCOST_PHASE_RST     32'h0000_0000

`endif

// ---- shared/dcost_pkg.sv ----
package dcost_pkg;

	// Steering source for the divider.
	typedef enum logic [5:0] {
		DCOST_MODE_LOOP    = 6'b00_0001,
		DCOST_MODE_DISC    = 6'b00_0010,
		DCOST_MODE_EXTLF   = 6'b00_0100,
		DCOST_MODE_WFREQ   = 6'b00_1000,
		DCOST_MODE_INCDEC  = 6'b01_0000,
		DCOST_MODE_WPHASE  = 6'b10_0000
	} dcost_mode_t;

	// Phase word timer states.
	typedef enum logic [2:0] {
		DCOST_TMR_IDLE  = 3'b001,
		DCOST_TMR_RUN   = 3'b010,
		DCOST_TMR_DONE  = 3'b100
	} dcost_tmr_t;

endpackage : dcost_pkg

// ---- rtl/dcost_steering.sv ----
// Notes on behaviour
// - Write-frequency mode bypasses detector and filter; written word steers divider.
// - New words change frequency only, never pulses; output holds until next word.
// - Frequency control word is 42-bit signed two's complement.
// - Word range spans +244.20ppm to -244.08ppm, step about 1.11e-10 ppm.
// - Positive frequency word raises output frequency, negative lowers it.
// - Increment/decrement adds or subtracts preset step to accumulated word.
// - General-purpose pins can trigger increment or decrement on this channel.
// - Write-phase word enters loop filter as measured error, limited; the code passes phaseWord to filterPhaseIn without limiting.
// - Phase timer expiry clears phase word or enters holdover.
// - Phase timer is 16-bit unsigned milliseconds, up to 65.535 seconds.
// - Phase word is 32-bit two's complement, 50ps step.
// - Positive phase word speeds output up, negative slows it.
// - External filter mode exposes decimated phase error for reading.
// - Jitter-attenuator loop tracks reference, holds over when references lost.
// - Oscillator discipline lets the system loop steer this divider.
// - Combined-channel offsets add on top of the written frequency offset.
`timescale 1ns/1ns
`default_nettype none
`include "dcost_defs.svh"

module dcost_steering #(
	parameter int unsigned TICK_CYCLES = `DCOST_TICK_CYCLES,
	parameter int unsigned DECIM_W     = 8
) (
	// Clock and reset.
	input  wire logic                              mclk,
	input  wire logic                              sys_rst,
	// Mode select.
	input  wire dcost_pkg::dcost_mode_t            mode,
	input  wire logic                              allRefsLost,
	// Frequency word staging, byte wise.
	input  wire logic [2:0]                        freqByteSel,
	input  wire logic [7:0]                        freqByteData,
	input  wire logic                              freqByteWrite,
	input  wire logic                              freqCommit,
	// Increment and decrement.
	input  wire logic [`DCOST_FREQ_W-1:0]          stepSize,
	input  wire logic                              incWrite,
	input  wire logic                              decWrite,
	input  wire logic                              incPin,
	input  wire logic                              decPin,
	input  wire logic                              pinTrigEnable,
	// Phase word staging and timer.
	input  wire logic [1:0]                        phaseByteSel,
	input  wire logic [7:0]                        phaseByteData,
	input  wire logic                              phaseByteWrite,
	input  wire logic                              phaseCommit,
	input  wire logic [`DCOST_TIMER_W-1:0]         phaseTimerMs,
	input  wire logic                              phaseTimerEnable,
	input  wire logic                              expiryHoldover,
	// Internal loop sources.
	input  wire logic signed [`DCOST_FREQ_W-1:0]   loopSteer,
	input  wire logic signed [`DCOST_FREQ_W-1:0]   discSteer,
	input  wire logic signed [`DCOST_FREQ_W-1:0]   comboOffset,
	input  wire logic signed [`DCOST_ERR_W-1:0]    detPhaseErr,
	input  wire logic                              detValid,
	input  wire logic [DECIM_W-1:0]                decimRatio,
	// Steering outputs.
	output logic signed [`DCOST_FREQ_W-1:0]        dividerSteer,
	output logic signed [`DCOST_PHASE_W-1:0]       filterPhaseIn,
	output logic                                   filterBypass,
	output logic                                   holdover,
	output logic signed [`DCOST_ERR_W-1:0]         extPhaseErr,
	output logic                                   extPhaseErrValid,
	output logic                                   phaseTimerExpired
);
	import dcost_pkg::*;

	// Saturating signed add so the steering word never wraps.
	function automatic logic signed [`DCOST_FREQ_W-1:0] satAdd(
		input logic signed [`DCOST_FREQ_W-1:0] a,
		input logic signed [`DCOST_FREQ_W-1:0] b
	);
		logic signed [`DCOST_FREQ_W:0] s;
		s = {a[`DCOST_FREQ_W-1], a} + {b[`DCOST_FREQ_W-1], b};
		if (s > $signed({1'b0, `DCOST_FREQ_MAX}))
			satAdd = `DCOST_FREQ_MAX;
		else if (s < $signed({1'b1, `DCOST_FREQ_MIN}))
			satAdd = `DCOST_FREQ_MIN;
		else
			satAdd = s[`DCOST_FREQ_W-1:0];
	endfunction : satAdd

	// Pin synchronisers and edge detect.
	logic [1:0] incSync;
	logic [1:0] decSync;
	logic       incLast;
	logic       decLast;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			incSync <= 2'h0;
			decSync <= 2'h0;
			incLast <= 1'b0;
			decLast <= 1'b0;
		end else begin
			incSync <= {incSync[0], incPin};
			decSync <= {decSync[0], decPin};
			incLast <= incSync[1];
			decLast <= decSync[1];
		end
	end
	logic pinInc;
	logic pinDec;
	assign pinInc = pinTrigEnable & incSync[1] & ~incLast;
	assign pinDec = pinTrigEnable & decSync[1] & ~decLast;

	// Frequency word staging and active word.
	logic [`DCOST_FREQ_REG_W-1:0]       freqStage;
	logic signed [`DCOST_FREQ_W-1:0]    freqWord;
	logic [`DCOST_FREQ_REG_W-1:0]       next_freqStage;
	logic signed [`DCOST_FREQ_W-1:0]    next_freqWord;
	always_comb begin
		next_freqStage = freqStage;
		next_freqWord  = freqWord;
		if (freqByteWrite && freqByteSel < 3'h6)
			next_freqStage[freqByteSel*8 +: 8] = freqByteData;
		if (freqCommit)
			// Only the low 42 bits carry the signed word; upper bits are sign extension.
			next_freqWord = signed'(freqStage[`DCOST_FREQ_W-1:0]);
		else if (incWrite || pinInc)
			next_freqWord = satAdd(freqWord, signed'(stepSize));
		else if (decWrite || pinDec)
			next_freqWord = satAdd(freqWord, -signed'(stepSize));
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			freqStage <= `DCOST_FREQ_RST;
			freqWord  <= '0;
		end else begin
			freqStage <= next_freqStage;
			freqWord  <= next_freqWord;
		end
	end

	// Phase word staging and timer.
	logic [`DCOST_PHASE_W-1:0]          phaseStage;
	logic signed [`DCOST_PHASE_W-1:0]   phaseWord;
	dcost_tmr_t                         tmrState;
	logic [`DCOST_TIMER_W-1:0]          msLeft;
	logic [31:0]                        tickCnt;
	logic                               expired;
	logic [`DCOST_PHASE_W-1:0]          next_phaseStage;
	logic signed [`DCOST_PHASE_W-1:0]   next_phaseWord;
	dcost_tmr_t                         next_tmrState;
	logic [`DCOST_TIMER_W-1:0]          next_msLeft;
	logic [31:0]                        next_tickCnt;
	logic                               next_expired;
	always_comb begin
		next_phaseStage = phaseStage;
		next_phaseWord  = phaseWord;
		next_tmrState   = tmrState;
		next_msLeft     = msLeft;
		next_tickCnt    = tickCnt;
		next_expired    = expired;
		if (phaseByteWrite)
			next_phaseStage[phaseByteSel*8 +: 8] = phaseByteData;
		if (phaseCommit) begin
			next_phaseWord = signed'(phaseStage);
			next_expired   = 1'b0;
			next_tickCnt   = '0;
			next_msLeft    = phaseTimerMs;
			next_tmrState  = (phaseTimerEnable && phaseTimerMs != '0)
				? DCOST_TMR_RUN : DCOST_TMR_IDLE;
		end else begin
			case (tmrState)
				DCOST_TMR_IDLE: begin
					next_tickCnt = '0;
				end
				DCOST_TMR_RUN: begin
					if (tickCnt == TICK_CYCLES - 1) begin
						next_tickCnt = '0;
						next_msLeft  = msLeft - 16'h0001;
						if (msLeft == 16'h0001) begin
							next_tmrState = DCOST_TMR_DONE;
							next_expired  = 1'b1;
							if (!expiryHoldover)
								next_phaseWord = '0;
						end
					end else begin
						next_tickCnt = tickCnt + 32'h0000_0001;
					end
				end
				DCOST_TMR_DONE: begin
					next_tickCnt = '0;
				end
				default: next_tmrState = DCOST_TMR_IDLE;
			endcase
		end
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			phaseStage <= `DCOST_PHASE_RST;
			phaseWord  <= '0;
			tmrState   <= DCOST_TMR_IDLE;
			msLeft     <= '0;
			tickCnt    <= '0;
			expired    <= 1'b0;
		end else begin
			phaseStage <= next_phaseStage;
			phaseWord  <= next_phaseWord;
			tmrState   <= next_tmrState;
			msLeft     <= next_msLeft;
			tickCnt    <= next_tickCnt;
			expired    <= next_expired;
		end
	end

	// Decimated detector error for the external filter.
	logic [DECIM_W-1:0]               decCnt;
	logic signed [`DCOST_ERR_W-1:0]   errHold;
	logic                             errValid;
	logic [DECIM_W-1:0]               next_decCnt;
	logic signed [`DCOST_ERR_W-1:0]   next_errHold;
	logic                             next_errValid;
	always_comb begin
		next_decCnt   = decCnt;
		next_errHold  = errHold;
		next_errValid = 1'b0;
		if (mode == DCOST_MODE_EXTLF && detValid) begin
			if (decCnt >= decimRatio) begin
				next_decCnt   = '0;
				next_errHold  = detPhaseErr;
				next_errValid = 1'b1;
			end else begin
				next_decCnt = decCnt + 1'b1;
			end
		end
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			decCnt   <= '0;
			errHold  <= '0;
			errValid <= 1'b0;
		end else begin
			decCnt   <= next_decCnt;
			errHold  <= next_errHold;
			errValid <= next_errValid;
		end
	end

	// Output steering selection; only frequency moves, so pulses stay intact.
	logic signed [`DCOST_FREQ_W-1:0]    next_steer;
	logic signed [`DCOST_PHASE_W-1:0]   next_filterIn;
	logic                               next_bypass;
	logic                               next_hold;
	always_comb begin
		next_steer    = dividerSteer;
		next_filterIn = '0;
		next_bypass   = 1'b0;
		next_hold     = 1'b0;
		case (mode)
			DCOST_MODE_LOOP: begin
				next_hold = allRefsLost;
				if (!allRefsLost)
					next_steer = loopSteer;
			end
			DCOST_MODE_DISC: next_steer = discSteer;
			DCOST_MODE_EXTLF, DCOST_MODE_WFREQ, DCOST_MODE_INCDEC: begin
				next_bypass = 1'b1;
				next_steer  = satAdd(freqWord, comboOffset);
			end
			DCOST_MODE_WPHASE: begin
				next_filterIn = phaseWord;
				next_hold     = expired & expiryHoldover;
				if (!next_hold)
					next_steer = loopSteer;
			end
			default: next_hold = 1'b1;
		endcase
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			dividerSteer      <= '0;
			filterPhaseIn     <= '0;
			filterBypass      <= 1'b0;
			holdover          <= 1'b0;
			extPhaseErr       <= '0;
			extPhaseErrValid  <= 1'b0;
			phaseTimerExpired <= 1'b0;
		end else begin
			dividerSteer      <= next_steer;
			filterPhaseIn     <= next_filterIn;
			filterBypass      <= next_bypass;
			holdover          <= next_hold;
			extPhaseErr       <= errHold;
			extPhaseErrValid  <= errValid;
			phaseTimerExpired <= expired;
		end
	end

endmodule : dcost_steering
`default_nettype wire

// ---- verif/dcost_steering_props.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "dcost_defs.svh"
module dcost_steering_props #(
	parameter int unsigned TICK_CYCLES = 10
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Watched inputs.
	input wire dcost_pkg::dcost_mode_t mode,
	input wire logic allRefsLost,
	input wire logic freqCommit,
	input wire logic incWrite,
	input wire logic decWrite,
	input wire logic pinTrigEnable,
	input wire logic phaseCommit,
	input wire logic expiryHoldover,
	input wire logic signed [`DCOST_FREQ_W-1:0] comboOffset,
	input wire logic detValid,
	// Watched outputs.
	input wire logic signed [`DCOST_FREQ_W-1:0] dividerSteer,
	input wire logic signed [`DCOST_PHASE_W-1:0] filterPhaseIn,
	input wire logic filterBypass,
	input wire logic holdover,
	input wire logic extPhaseErrValid,
	input wire logic phaseTimerExpired
);
	import dcost_pkg::*;
	logic [1:0] upCnt;
	logic [1:0] next_upCnt;
	// Holds the bypass, phase-idle and steer-hold checks off until outputs have left their reset values.
	always_comb begin
		next_upCnt = (upCnt == 2'h3) ? upCnt : upCnt + 2'h1;
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			upCnt <= 2'h0;
		end else begin
			upCnt <= next_upCnt;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	bypass_mode_a: assert property ((upCnt == 2'h3 && $stable(mode)) [*2] |=>
		filterBypass == ($past(mode) inside {DCOST_MODE_EXTLF, DCOST_MODE_WFREQ, DCOST_MODE_INCDEC}))
		else $error("bypass does not follow mode");
	phase_idle_a: assert property ((upCnt == 2'h3 && $stable(mode)
		&& mode != DCOST_MODE_WPHASE) [*2] |=> filterPhaseIn == '0)
		else $error("phase word reaches filter outside write-phase");
	steer_hold_a: assert property (upCnt == 2'h3 && mode == DCOST_MODE_WFREQ
		&& $stable(mode) && $stable(comboOffset) && !pinTrigEnable && !$past(freqCommit)
		&& !$past(incWrite) && !$past(decWrite) |=> $stable(dividerSteer))
		else $error("steering word moved without a commit");
	err_valid_a: assert property (extPhaseErrValid |->
		$past(detValid, 2) && $past(mode, 2) == DCOST_MODE_EXTLF)
		else $error("phase error output without a sample");
	refs_lost_a: assert property ((mode == DCOST_MODE_LOOP && allRefsLost) [*3] |-> holdover)
		else $error("no holdover with references lost");
	expire_clear_a: assert property ($rose(phaseTimerExpired) && !expiryHoldover
		|-> ##[0:2] filterPhaseIn == '0)
		else $error("phase word not cleared at expiry");
	expire_hold_a: assert property ($rose(phaseTimerExpired) && expiryHoldover
		|-> ##[0:2] holdover)
		else $error("no holdover at expiry");
	expire_sticky_a: assert property (phaseTimerExpired && !phaseCommit
		&& !$past(phaseCommit) |=> phaseTimerExpired)
		else $error("expiry flag dropped without a commit");
	cover property (extPhaseErrValid);
	cover property ($rose(phaseTimerExpired));
	cover property (holdover && mode == DCOST_MODE_LOOP);
endmodule : dcost_steering_props
bind dcost_steering dcost_steering_props #(.TICK_CYCLES(TICK_CYCLES)) dcost_steering_props_inst (
	.mclk(mclk), .sys_rst(sys_rst), .mode(mode), .allRefsLost(allRefsLost),
	.freqCommit(freqCommit), .incWrite(incWrite), .decWrite(decWrite),
	.pinTrigEnable(pinTrigEnable), .phaseCommit(phaseCommit),
	.expiryHoldover(expiryHoldover), .comboOffset(comboOffset), .detValid(detValid),
	.dividerSteer(dividerSteer), .filterPhaseIn(filterPhaseIn), .filterBypass(filterBypass),
	.holdover(holdover), .extPhaseErrValid(extPhaseErrValid),
	.phaseTimerExpired(phaseTimerExpired));
`default_nettype wire

// ---- verif/dcost_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module dcost_host_model (
	// Clock and request.
	input wire logic mclk,
	input wire logic go,
	input wire logic isPh,
	input wire logic slow,
	input wire logic [41:0] word,
	// Byte writes.
	output logic [2:0] bSel,
	output logic [7:0] bData,
	output logic fWr,
	output logic pWr,
	output logic fGo,
	output logic pGo,
	output logic busy
);
	logic [47:0] w48;
	initial begin
		{bSel, bData, fWr, pWr, fGo, pGo, busy} = '0;
		forever begin
			@(posedge mclk);
			if (go) begin
				busy <= 1'b1;
				w48 = isPh ? {16'h0000, word[31:0]} : {{6{word[41]}}, word};
				for (int n = 0; n < (isPh ? 4 : 6); n++) begin
					bSel <= n[2:0];
					bData <= w48[8*n +: 8];
					fWr <= !isPh;
					pWr <= isPh;
					@(posedge mclk);
					if (slow) begin
						fWr <= 1'b0;
						pWr <= 1'b0;
						bData <= ~w48[8*n +: 8];
						@(posedge mclk);
					end
				end
				fWr <= 1'b0;
				pWr <= 1'b0;
				bData <= ~bData;
				fGo <= !isPh;
				pGo <= isPh;
				@(posedge mclk);
				fGo <= 1'b0;
				pGo <= 1'b0;
				busy <= 1'b0;
			end
		end
	end
endmodule : dcost_host_model
`default_nettype wire

// ---- verif/dcost_steering_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "dcost_defs.svh"
module dcost_steering_tb_top;
	import dcost_pkg::*;
	localparam int TK = 10;
	localparam logic signed [41:0] A = 42'sh1234;
	localparam logic signed [41:0] B = -42'sh0567;
	localparam logic signed [41:0] C = 42'sh03E8;
	localparam logic signed [41:0] S = 42'sh0100;
	localparam logic signed [31:0] P = -32'sh0007;
	logic mclk = 1'b0, sys_rst = 1'b1, go = 1'b0, isPh = 1'b0, slow = 1'b0;
	logic allRefsLost = 1'b0, incWrite = 1'b0, decWrite = 1'b0, incPin = 1'b0, decPin = 1'b0;
	logic pinTrigEnable = 1'b0, phaseTimerEnable = 1'b1, expiryHoldover = 1'b0, detValid = 1'b0;
	logic [15:0] phaseTimerMs = 16'h0001;
	logic [7:0] decimRatio = 8'h02;
	logic [41:0] word = '0, stepSize = S;
	logic signed [41:0] loopSteer = A, discSteer = B, comboOffset = '0, dividerSteer;
	logic signed [31:0] detPhaseErr = '0, filterPhaseIn, extPhaseErr, lastErr;
	logic filterBypass, holdover, extPhaseErrValid, phaseTimerExpired, fWr, pWr, fGo, pGo, busy;
	logic [2:0] bSel;
	logic [7:0] bData;
	dcost_mode_t mode = DCOST_MODE_LOOP;
	int compares = 0, failures = 0, cycles = 0, nErr = 0;
	dcost_steering #(.TICK_CYCLES(TK)) dcost_steering_inst (
		.mclk(mclk), .sys_rst(sys_rst), .mode(mode), .allRefsLost(allRefsLost),
		.freqByteSel(bSel), .freqByteData(bData), .freqByteWrite(fWr), .freqCommit(fGo),
		.stepSize(stepSize), .incWrite(incWrite), .decWrite(decWrite), .incPin(incPin),
		.decPin(decPin), .pinTrigEnable(pinTrigEnable), .phaseByteSel(bSel[1:0]),
		.phaseByteData(bData), .phaseByteWrite(pWr), .phaseCommit(pGo),
		.phaseTimerMs(phaseTimerMs), .phaseTimerEnable(phaseTimerEnable),
		.expiryHoldover(expiryHoldover), .loopSteer(loopSteer), .discSteer(discSteer),
		.comboOffset(comboOffset), .detPhaseErr(detPhaseErr), .detValid(detValid),
		.decimRatio(decimRatio), .dividerSteer(dividerSteer), .filterPhaseIn(filterPhaseIn),
		.filterBypass(filterBypass), .holdover(holdover), .extPhaseErr(extPhaseErr),
		.extPhaseErrValid(extPhaseErrValid), .phaseTimerExpired(phaseTimerExpired));
	dcost_host_model dcost_host_model_inst (.mclk(mclk), .go(go), .isPh(isPh), .slow(slow),
		.word(word), .bSel(bSel), .bData(bData), .fWr(fWr), .pWr(pWr), .fGo(fGo), .pGo(pGo),
		.busy(busy));
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (extPhaseErrValid === 1'b1) begin
			nErr++;
			lastErr = extPhaseErr;
		end
		if (cycles == 3000) begin
			failures++;
			results();
		end
	end
	function automatic logic signed [41:0] fcwOf(input real ppm);
		return 42'(longint'((1.0 - 1.0 / (1.0 + ppm / 1.0e6)) * 2.0 ** 53));
	endfunction : fcwOf
	task automatic chk(input logic [47:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : settle
	task automatic host(input logic ph, sl, input logic [41:0] w);
		@(posedge mclk) isPh <= ph;
		slow <= sl;
		word <= w;
		go <= 1'b1;
		@(posedge mclk) go <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < 40 && busy; i++) @(posedge mclk);
		settle(3);
	endtask : host
	task automatic results;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	initial begin
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			@(posedge mclk) mode <= dcost_mode_t'(6'h01 << i);
			settle(3);
			chk(filterBypass, i inside {[2:4]});
			chk(dividerSteer, i == 1 ? B : (i == 0 || i == 5) ? A : 42'sh0);
		end
		@(posedge mclk) mode <= dcost_mode_t'(6'h00);
		settle(3);
		chk(holdover, 1'b1);
		chk(dividerSteer, A);
		$display("mode sweep done");
		@(posedge mclk) mode <= DCOST_MODE_LOOP;
		allRefsLost <= 1'b1;
		settle(3);
		chk(holdover, 1'b1);
		@(posedge mclk) loopSteer <= B;
		settle(3);
		chk(dividerSteer, A);
		@(posedge mclk) allRefsLost <= 1'b0;
		mode <= DCOST_MODE_EXTLF;
		for (int k = 1; k <= 6; k++) begin
			@(posedge mclk) detValid <= 1'b1;
			detPhaseErr <= 32'sh0100 + k;
		end
		@(posedge mclk) detValid <= 1'b0;
		settle(4);
		chk(nErr, 2);
		chk(lastErr, 32'sh0106);
		$display("holdover and decimation done");
		@(posedge mclk) mode <= DCOST_MODE_WFREQ;
		comboOffset <= C;
		host(1'b0, 1'b0, fcwOf(1.0));
		chk(dividerSteer, fcwOf(1.0) + C);
		fork
			host(1'b0, 1'b1, fcwOf(-5.0));
			begin
				settle(8);
				chk(dividerSteer, fcwOf(1.0) + C);
			end
		join
		chk(dividerSteer, fcwOf(-5.0) + C);
		@(posedge mclk) mode <= DCOST_MODE_INCDEC;
		incWrite <= 1'b1;
		@(posedge mclk);
		@(posedge mclk) incWrite <= 1'b0;
		decWrite <= 1'b1;
		@(posedge mclk) decWrite <= 1'b0;
		settle(3);
		chk(dividerSteer, fcwOf(-5.0) + S + C);
		@(posedge mclk) pinTrigEnable <= 1'b1;
		incPin <= 1'b1;
		settle(8);
		chk(dividerSteer, fcwOf(-5.0) + S + S + C);
		@(posedge mclk) decPin <= 1'b1;
		settle(8);
		chk(dividerSteer, fcwOf(-5.0) + S + C);
		@(posedge mclk) pinTrigEnable <= 1'b0;
		$display("frequency writes done");
		@(posedge mclk) mode <= DCOST_MODE_WPHASE;
		host(1'b1, 1'b0, 42'(P));
		chk(filterPhaseIn, P);
		chk(phaseTimerExpired, 1'b0);
		settle(2 * TK);
		chk(phaseTimerExpired, 1'b1);
		chk(filterPhaseIn, 32'sh0);
		@(posedge mclk) expiryHoldover <= 1'b1;
		host(1'b1, 1'b0, 42'sh0003);
		chk(holdover, 1'b0);
		settle(2 * TK);
		chk(holdover, 1'b1);
		@(posedge mclk) phaseTimerEnable <= 1'b0;
		host(1'b1, 1'b0, 42'sh0002);
		settle(2 * TK);
		chk(phaseTimerExpired, 1'b0);
		chk(filterPhaseIn, 32'sh0002);
		$display("phase writes done");
		results();
	end
endmodule : dcost_steering_tb_top
`default_nettype wire
